// *** ccdlm_core.sv ***
// Loop memory device logic: pin sampling, page walk, bit access, status.
`timescale 1ns/100ps
`include "ccdlm_map.svh"
module ccdlm_core
    import ccdlm_pkg::*;
#(
    parameter int ADDR_W = `CCDLM_ADDR_W,
    parameter int PAGES  = `CCDLM_LOOP_BITS
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire logic                    link_clk,
    input  wire ccdlm_pins_s             pins,
    output logic                         data_out,
    output logic                         data_oe_n,
    output logic                         sys_page_open,
    output logic [`CCDLM_SUB_W-1:0]      sys_page_sub
);
    localparam int FLOAT_CYC = `CCDLM_FLOAT_NS / `CCDLM_SYS_NS;

    logic                     rst_s1_r;
    logic                     rst_s2_r;
    logic                     rst_s3_r;
    logic                     link_rst_n_r;
    ccdlm_pins_s              s1_r;
    ccdlm_pins_s              s2_r;
    ccdlm_pins_s              s3_r;
    ccdlm_pins_s              q_r;
    ccdlm_pins_s              qd_r;
    ccdlm_pins_s              q_nxt;
    ccdlm_phase_e             phase_r;
    ccdlm_phase_e             phase_nxt;
    logic [`CCDLM_SUB_W-1:0]  sub_r;
    logic [`CCDLM_SUB_W-1:0]  sub_nxt;
    logic [`CCDLM_GRP_W-1:0]  grp_r;
    logic [`CCDLM_SUB_W-1:0]  gray_r;
    logic                     open_r;
    logic [PAGES-1:0]         mem_r [PAGES];
    logic                     link_rst_n;
    logic                     se_rise;
    logic                     sy_rise;
    logic                     sel;
    logic                     wr;
    logic                     page_ok;
    logic [ADDR_W-1:0]        cur_page;
    logic [PAGES-1:0]         cur_row;
    logic                     rd_fire;
    logic                     wr_fire;
    logic                     oe_n_nxt;
    logic                     so1_r;
    logic                     so2_r;
    logic                     so3_r;
    logic                     open_out_r;
    logic [`CCDLM_SUB_W-1:0]  sg1_r;
    logic [`CCDLM_SUB_W-1:0]  sg2_r;
    logic [`CCDLM_SUB_W-1:0]  sg3_r;
    logic [`CCDLM_SUB_W-1:0]  sub_out_r;

    // Link-domain reset is taken over from the system reset.
    always_ff @(posedge link_clk) begin
        rst_s1_r <= reset_n;
        rst_s2_r <= rst_s1_r;
        rst_s3_r <= rst_s2_r;
        if (rst_s2_r == rst_s3_r) begin
            link_rst_n_r <= rst_s3_r;
        end
    end
    assign link_rst_n = link_rst_n_r;

    // Pins pass three flops; a bit moves once stages two and three agree.
    assign q_nxt = (s2_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
    always_ff @(posedge link_clk) begin
        s1_r <= pins;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            q_r  <= '{default: '0, chip_sel_n: 1'b1, write_en_n: 1'b1};
            qd_r <= '{default: '0, chip_sel_n: 1'b1, write_en_n: 1'b1};
        end else begin
            q_r  <= q_nxt;
            qd_r <= q_r;
        end
    end

    assign se_rise  = q_r.page_step_clock & ~qd_r.page_step_clock;
    assign sy_rise  = q_r.shift_strobe & ~qd_r.shift_strobe;
    assign sel      = ~q_r.chip_sel_n;
    assign wr       = ~q_r.write_en_n;
    assign page_ok  = (phase_r == PH_OPEN);
    assign cur_page = {grp_r, sub_r};
    assign cur_row  = mem_r[cur_page];
    assign rd_fire  = sel & ~wr & page_ok;
    assign wr_fire  = sel & wr & page_ok;
    assign oe_n_nxt = ~rd_fire;

    // Page walk: the strobe arms the next group, page-step edges open pages.
    always_comb begin
        phase_nxt = phase_r;
        sub_nxt   = sub_r;
        case (phase_r)
            PH_IDLE: begin
                if (sy_rise) begin
                    phase_nxt = PH_ARMED;
                end
            end
            PH_ARMED: begin
                if (se_rise) begin
                    phase_nxt = PH_OPEN;
                    sub_nxt   = `CCDLM_SUB_FIRST;
                end
            end
            PH_OPEN: begin
                if (sy_rise) begin
                    phase_nxt = PH_ARMED;
                end else if (se_rise && sub_r == `CCDLM_SUB_LAST) begin
                    phase_nxt = PH_IDLE;
                end else if (se_rise) begin
                    sub_nxt   = sub_r + `CCDLM_SUB_ONE;
                end
            end
            default: begin
                phase_nxt = PH_IDLE;
            end
        endcase
        if (phase_r != PH_IDLE && phase_r != PH_OPEN && sy_rise) begin
            phase_nxt = PH_ARMED;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            phase_r <= PH_IDLE;
            sub_r   <= `CCDLM_SUB_FIRST;
            grp_r   <= '0;
        end else begin
            phase_r <= phase_nxt;
            sub_r   <= sub_nxt;
            if (sy_rise) begin
                grp_r <= grp_r + `CCDLM_GRP_ONE;
            end
        end
    end

    // Bit storage; the page pointer stands in for rotating every loop.
    always_ff @(posedge link_clk) begin
        if (wr_fire) begin
            mem_r[cur_page][q_r.addr] <= q_r.data_in;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            data_out  <= 1'b0;
            data_oe_n <= 1'b1;
            open_r    <= 1'b0;
            gray_r    <= '0;
        end else begin
            data_oe_n <= oe_n_nxt;
            if (rd_fire) begin
                data_out <= cur_row[q_r.addr];
            end
            open_r <= page_ok;
            gray_r <= sub_r ^ (sub_r >> 1);
        end
    end

    // Page status crosses to the system clock as a level and a gray code.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            so1_r      <= 1'b0;
            so2_r      <= 1'b0;
            so3_r      <= 1'b0;
            sg1_r      <= '0;
            sg2_r      <= '0;
            sg3_r      <= '0;
            open_out_r <= 1'b0;
            sub_out_r  <= '0;
        end else begin
            so1_r <= open_r;
            so2_r <= so1_r;
            so3_r <= so2_r;
            sg1_r <= gray_r;
            sg2_r <= sg1_r;
            sg3_r <= sg2_r;
            if (so2_r == so3_r) begin
                open_out_r <= so3_r;
            end
            if (sg2_r == sg3_r) begin
                sub_out_r <= {sg3_r[1], sg3_r[1] ^ sg3_r[0]};
            end
        end
    end
    assign sys_page_open = open_out_r;
    assign sys_page_sub  = sub_out_r;

    property p_float_deselect;
        @(posedge link_clk) disable iff (!link_rst_n)
        !sel |-> ##[1:FLOAT_CYC] data_oe_n;
    endproperty
    a_float_deselect: assert property (p_float_deselect)
        else $error("Output still driven after deselect.");

    property p_float_write;
        @(posedge link_clk) disable iff (!link_rst_n)
        (sel && wr) |=> data_oe_n;
    endproperty
    a_float_write: assert property (p_float_write)
        else $error("Output driven during write strobe.");

    property p_ignore_deselected;
        @(posedge link_clk) disable iff (!link_rst_n)
        (!sel && !se_rise && !sy_rise) |=> $stable(cur_row);
    endproperty
    a_ignore_deselected: assert property (p_ignore_deselected)
        else $error("Page changed while deselected.");

    property p_strobe_closes;
        @(posedge link_clk) disable iff (!link_rst_n)
        sy_rise |=> !page_ok && (grp_r == $past(grp_r) + `CCDLM_GRP_ONE);
    endproperty
    a_strobe_closes: assert property (p_strobe_closes)
        else $error("Strobe did not advance the group.");

    property p_first_page;
        @(posedge link_clk) disable iff (!link_rst_n)
        (phase_r == PH_ARMED && se_rise && !sy_rise) |=>
            page_ok && sub_r == `CCDLM_SUB_FIRST;
    endproperty
    a_first_page: assert property (p_first_page)
        else $error("First page not opened after strobe.");

    property p_next_page;
        @(posedge link_clk) disable iff (!link_rst_n)
        (page_ok && se_rise && !sy_rise && sub_r != `CCDLM_SUB_LAST) |=>
            page_ok && sub_r == $past(sub_r) + `CCDLM_SUB_ONE;
    endproperty
    a_next_page: assert property (p_next_page)
        else $error("Page-step did not advance the page.");

    property p_closed_after_last;
        @(posedge link_clk) disable iff (!link_rst_n)
        (page_ok && se_rise && !sy_rise && sub_r == `CCDLM_SUB_LAST) |=>
            !page_ok ##1 (!page_ok || $past(sy_rise) || $past(se_rise));
    endproperty
    a_closed_after_last: assert property (p_closed_after_last)
        else $error("Page stayed open after the fourth page.");

    property p_read_data;
        @(posedge link_clk) disable iff (!link_rst_n)
        rd_fire |=> !data_oe_n && data_out === $past(cur_row[q_r.addr]);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("Read bit not presented.");

    property p_write_data;
        @(posedge link_clk) disable iff (!link_rst_n)
        (wr_fire && !se_rise && !sy_rise) |=>
            cur_row[$past(q_r.addr)] == $past(q_r.data_in);
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("Written bit not stored.");

    property p_cov_read;
        @(posedge link_clk) disable iff (!link_rst_n) rd_fire ##1 !sel;
    endproperty
    c_read: cover property (p_cov_read);

    property p_cov_rmw;
        @(posedge link_clk) disable iff (!link_rst_n) rd_fire ##[1:8] wr_fire;
    endproperty
    c_rmw: cover property (p_cov_rmw);

    property p_cov_walk;
        @(posedge link_clk) disable iff (!link_rst_n)
        page_ok && sub_r == `CCDLM_SUB_LAST && se_rise;
    endproperty
    c_walk: cover property (p_cov_walk);
endmodule : ccdlm_core

// *** ccdlm_map.svh ***
// Constants of the loop memory interface.
`ifndef CCDLM_MAP_SVH
`define CCDLM_MAP_SVH
`define CCDLM_ADDR_W    8
`define CCDLM_LOOP_BITS 256
`define CCDLM_SUB_W     2
`define CCDLM_GRP_W     6
`define CCDLM_SUB_FIRST 2'h0
`define CCDLM_SUB_LAST  2'h3
`define CCDLM_SUB_ONE   2'h1
`define CCDLM_GRP_ONE   6'h01
`define CCDLM_FLOAT_NS  60
`define CCDLM_SYS_NS    8
`endif

// *** ccdlm_pkg.sv ***
// Types shared by the loop memory interface.
`include "ccdlm_map.svh"
package ccdlm_pkg;
    typedef struct packed {
        logic                     page_step_clock;
        logic                     shift_strobe;
        logic                     chip_sel_n;
        logic                     write_en_n;
        logic                     data_in;
        logic [`CCDLM_ADDR_W-1:0] addr;
    } ccdlm_pins_s;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ARMED,
        PH_OPEN
    } ccdlm_phase_e;
endpackage : ccdlm_pkg

// *** ccdlm_ctrl_model.sv ***
// Controller model driving shift clocks and bit accesses.
`timescale 1ns/100ps
module ccdlm_ctrl_model
    import ccdlm_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   data_out,
    input  wire logic   data_oe_n,
    output ccdlm_pins_s pins
);
    initial pins = 13'h0600;

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : w

    task automatic pstep(input bit strb);
        if (strb) begin
            pins.shift_strobe <= 1'b1;
            w(20);
            pins.shift_strobe <= 1'b0;
            w(30);
        end
        pins.page_step_clock <= 1'b1;
        w(80);
        pins.page_step_clock <= 1'b0;
        w(13);
    endtask : pstep

    task automatic acc(input bit sel, wr, d, input logic [7:0] a,
                       output logic rd, oe_rd, oe_wr, oe_off);
        pins.chip_sel_n <= !sel;
        pins.addr       <= a;
        pins.data_in    <= d;
        w(8);
        rd    = data_oe_n ? ~data_out : data_out;
        oe_rd = data_oe_n;
        pins.write_en_n <= !wr;
        w(7);
        oe_wr = data_oe_n;
        w(6);
        pins.chip_sel_n <= 1'b1;
        pins.write_en_n <= 1'b1;
        pins.addr       <= ~a;
        pins.data_in    <= ~d;
        w(7);
        oe_off = data_oe_n;
        w(5);
    endtask : acc
endmodule : ccdlm_ctrl_model

// *** tb_ccd_loop_memory_interface.sv ***
// Bench: rotates every page twice, writes bits, reads them back.
`timescale 1ns/100ps
module tb_ccd_loop_memory_interface;
    import ccdlm_pkg::*;
    logic        sys_clk;
    logic        link_clk;
    logic        reset_n;
    logic        data_out;
    logic        data_oe_n;
    logic        sys_page_open;
    logic [1:0]  sys_page_sub;
    ccdlm_pins_s pins;
    int          bad_count;
    int          checks_done;
    bit          mem_q[int];
    logic [7:0]  addr_q[int];
    logic        rd, oe_rd, oe_wr, oe_off;

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    ccdlm_core DUT (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .link_clk      (link_clk),
        .pins          (pins),
        .data_out      (data_out),
        .data_oe_n     (data_oe_n),
        .sys_page_open (sys_page_open),
        .sys_page_sub  (sys_page_sub)
    );
    ccdlm_ctrl_model u_ctl (
        .sys_clk   (sys_clk),
        .data_out  (data_out),
        .data_oe_n (data_oe_n),
        .pins      (pins)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [7:0] a;
        logic       d;
        bad_count   = 0;
        checks_done = 0;
        reset_n     = 1'b0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        void'($urandom(60247));
        u_ctl.acc(1'b1, 1'b1, 1'b1, 8'h00, rd, oe_rd, oe_wr, oe_off);
        chk(8'(oe_rd), 8'h01);
        chk(8'(sys_page_open), 8'h00);
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 256; p++) begin
                u_ctl.pstep(p % 4 == 0);
                chk(8'(sys_page_open), 8'h01);
                chk(8'(sys_page_sub), 8'(p % 4));
                if (r == 0)
                    addr_q[p] = 8'($urandom);
                for (int k = 0; k < 2; k++) begin
                    a = addr_q[p] + 8'(k);
                    if (r == 0) begin
                        d = 1'($urandom);
                        u_ctl.acc(1'b1, 1'b1, d, a, rd, oe_rd, oe_wr, oe_off);
                        mem_q[p * 256 + int'(a)] = d;
                        chk(8'(oe_rd), 8'h00);
                        chk(8'(oe_wr), 8'h01);
                    end else begin
                        u_ctl.acc(1'b1, 1'b0, 1'b0, a, rd, oe_rd, oe_wr, oe_off);
                        chk(8'(oe_rd), 8'h00);
                        chk(8'(rd), 8'(mem_q[p * 256 + int'(a)]));
                        chk(8'(oe_wr), 8'h00);
                    end
                    chk(8'(oe_off), 8'h01);
                end
                if (r == 0 && p % 4 == 0) begin
                    u_ctl.acc(1'b0, 1'b1, ~d, a, rd, oe_rd, oe_wr, oe_off);
                    chk(8'(oe_rd), 8'h01);
                end
            end
        end
        u_ctl.pstep(1'b0);
        chk(8'(sys_page_open), 8'h00);
        u_ctl.acc(1'b1, 1'b0, 1'b0, a, rd, oe_rd, oe_wr, oe_off);
        chk(8'(oe_rd), 8'h01);
        end_of_test();
    end
endmodule : tb_ccd_loop_memory_interface
